/* i2c_master_rx_model.sv */
// bus-master receiver model pulling the two-wire lines low through open drains
`timescale 1ns/10ps
module i2c_master_rx_model
(
	input wire logic sclW,
	input wire logic sdaW,
	output logic mScl,
	output logic mSda
);
	localparam real Q = 31.25;
	initial
	begin
		mScl = 1'b0;
		mSda = 1'b0;
	end
	// ----------------------------------------
	// line tasks
	// ----------------------------------------
	// high phase starts only once the wire is high, so slave stretching is honoured
	task automatic bitIo(input logic o, output logic v);
		#Q;
		mSda = !o;
		#Q;
		mScl = 1'b0;
		wait (sclW === 1'b1);
		#Q;
		v = sdaW;
		#Q;
		mScl = 1'b1;
	endtask
	task automatic start();
		mSda = 1'b0;
		#Q;
		mScl = 1'b0;
		wait (sclW === 1'b1);
		#(2*Q);
		mSda = 1'b1;
		#(2*Q);
		mScl = 1'b1;
	endtask
	task automatic stop();
		#Q;
		mSda = 1'b1;
		#Q;
		mScl = 1'b0;
		wait (sclW === 1'b1);
		#(2*Q);
		mSda = 1'b0;
		#(4*Q);
	endtask
	task automatic sendBits(input logic [7:0] v, input int n);
		logic x;
		for (int i = 0; i < n; i++)
			bitIo(v[7-i], x);
	endtask
	task automatic addrByte(input logic [6:0] adr, output logic ack);
		sendBits({adr, 1'b1}, 8);
		bitIo(1'b1, ack);
	endtask
	task automatic readByte(input logic mAck, output logic [7:0] d);
		logic x;
		for (int i = 0; i < 8; i++)
		begin
			bitIo(1'b1, x);
			d = {d[6:0], x};
		end
		bitIo(!mAck, x);
	endtask
endmodule

/* i2c_slave_tx.sv */
// slave-transmitter status engine of a two-wire serial interface with an AHB-Lite register port
`timescale 1ns/10ps

// Behaviour
// [R1] own address with read bit acknowledged: status A8, job flag raised
// [R2] resume with ack-enable clear sends loaded byte as final, expects NOT ACK
// [R3] resume with ack-enable set sends loaded byte, expects ACK for more
// [R4] lost arbitration then addressed for reading: status B0, continue as transmitter
// [R5] data byte acknowledged: status B8, wait for next load and resume
// [R6] data byte not acknowledged: status C0, resume goes not-addressed
// [R7] final byte acknowledged anyway: status C8, resume goes not-addressed
// [R8] address recognition follows ack-enable; general call needs general-call-enable
// [R9] resume with start request: not-addressed, START once bus is free
// [R10] status reads F8 whenever the job flag is clear
// [R11] START or STOP inside a byte or ack bit is a bus error, status 00
// [R12] bus error raises the job flag
// [R13] software recovers with stop request set and job flag written one
// [R14] recovery: not-addressed, clear only stop request, release lines, no STOP
// [R15] repeated START keeps the transfer going without freeing the bus
// [R16] software does pointer-write then read as one repeated-START transfer
// [R17] writing one to the job flag clears it and starts the next action
// [R18] SCL low period stretched while the job flag is set; the code does not stretch it for status 00 or while enable is clear
// [R19] own-address bit 0 enables general call, upper seven bits hold address
// [R20] status code in bits 7..3, prescaler in low bits
// [R21] byte driven MSB first in SCL low phases, SDA released for ack
module i2c_slave_tx
#(
	parameter int ADDR_W = 32
)
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [ADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic arbLostInAddr,
	input wire logic sclIn,
	output logic sclOut,
	output logic sclOe,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	output logic jobComplete
);
	import i2c_st_pkg::*;

	// the decoder slices haddr[ADDR_W-1:4], so narrower buses cannot be served
	if (ADDR_W < 5)
	begin : g_addr_w_check
		$error("ADDR_W too small for the register map");
	end

	// ----------------------------------------
	// decoding
	// ----------------------------------------
	function automatic logic isReg(input logic [3:0] low, input logic [3:0] off);
		isReg = (low == off);
	endfunction

	state_e state;
	ctrl_s ctrl;
	logic [7:0] dataReg;
	logic [7:0] ownAddr;
	logic [1:0] prescale;
	logic writeCollision;
	logic [7:0] statusCode;
	logic [7:0] shiftReg;
	logic [3:0] bitCnt;
	logic lastByte;
	logic ackSeen;
	logic gotAck;
	logic arbPending;
	logic busBusy;
	logic startPending;
	logic [8:0] holdCnt;
	logic sclS1, sclS2, sclPrev;
	logic sdaS1, sdaS2, sdaPrev;
	logic wrPend;
	logic [3:0] wrAddr;
	logic highOk;

	// ----------------------------------------
	// AHB-Lite slave
	// ----------------------------------------
	logic addrPhase;
	logic ctrlWrite;
	logic resume;
	logic recover;
	logic [7:0] statusField;

	assign addrPhase = hsel && hready && htrans[1];
	assign highOk = (haddr[ADDR_W-1:4] == '0) && (haddr[1:0] == 2'b00);
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign ctrlWrite = wrPend && isReg(wrAddr, OFF_CTRL);
	assign resume = ctrlWrite && hwdata[CB_JOB] && jobComplete; // R17
	assign recover = resume && (statusCode == ST_BUS_ERROR) && hwdata[CB_STO]; // R13
	assign statusField = jobComplete ? statusCode : ST_NO_INFO; // R10

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			wrPend <= 1'b0;
			wrAddr <= 4'h0;
		end
		else
		begin
			wrPend <= addrPhase && hwrite && highOk;
			wrAddr <= haddr[3:0];
		end
	end

	// read data is captured in the address phase, so reads never wait
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			hrdata <= 32'h0000_0000;
		else if (addrPhase && !hwrite)
		begin
			hrdata <= 32'h0000_0000;
			if (highOk)
			begin
				if (isReg(haddr[3:0], OFF_CTRL))
					hrdata[7:0] <= {jobComplete, ctrl.ackEnable, ctrl.startRequest,
						ctrl.stopRequest, writeCollision, ctrl.enable, 2'b00};
				else if (isReg(haddr[3:0], OFF_STATUS))
					hrdata[7:0] <= {statusField[7:3], 1'b0, prescale}; // R20
				else if (isReg(haddr[3:0], OFF_DATA))
					hrdata[7:0] <= dataReg;
				else if (isReg(haddr[3:0], OFF_OWNADDR))
					hrdata[7:0] <= ownAddr;
			end
		end
	end

	// ----------------------------------------
	// software registers
	// ----------------------------------------
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			ctrl <= '0;
		else if (ctrlWrite)
		begin
			ctrl.ackEnable <= hwdata[CB_ACK];
			ctrl.startRequest <= hwdata[CB_STA];
			ctrl.stopRequest <= recover ? 1'b0 : hwdata[CB_STO]; // R14
			ctrl.enable <= hwdata[CB_EN];
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			dataReg <= RST_DATA;
			ownAddr <= RST_OWNADDR;
			prescale <= RST_PRESCALE;
			writeCollision <= 1'b0;
		end
		else if (wrPend)
		begin
			if (isReg(wrAddr, OFF_DATA))
			begin
				// the byte is only writable while the engine waits on software
				if (jobComplete)
					dataReg <= hwdata[7:0];
				writeCollision <= !jobComplete;
			end
			if (isReg(wrAddr, OFF_OWNADDR))
				ownAddr <= hwdata[7:0]; // R19
			if (isReg(wrAddr, OFF_STATUS))
				prescale <= hwdata[1:0];
		end
	end

	// ----------------------------------------
	// line synchronisers and conditions
	// ----------------------------------------
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			sclS1 <= 1'b1;
			sclS2 <= 1'b1;
			sclPrev <= 1'b1;
			sdaS1 <= 1'b1;
			sdaS2 <= 1'b1;
			sdaPrev <= 1'b1;
		end
		else
		begin
			sclS1 <= sclIn;
			sclS2 <= sclS1;
			sclPrev <= sclS2;
			sdaS1 <= sdaIn;
			sdaS2 <= sdaS1;
			sdaPrev <= sdaS2;
		end
	end

	logic sclRise, sclFall, startDet, stopDet;
	assign sclRise = sclS2 && !sclPrev;
	assign sclFall = !sclS2 && sclPrev;
	assign startDet = sclS2 && sclPrev && sdaPrev && !sdaS2;
	assign stopDet = sclS2 && sclPrev && !sdaPrev && sdaS2;

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			busBusy <= 1'b0;
		else if (startDet)
			busBusy <= 1'b1; // R15
		else if (stopDet)
			busBusy <= 1'b0;
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			arbPending <= 1'b0;
		else if (arbLostInAddr)
			arbPending <= 1'b1;
		else if (state == S_ADDR_ACK && sclFall)
			arbPending <= 1'b0;
	end

	// ----------------------------------------
	// address match
	// ----------------------------------------
	logic ownMatch, gcMatch, addrAck;
	assign ownMatch = (shiftReg[7:1] == ownAddr[7:1]); // R19
	assign gcMatch = (shiftReg[7:1] == GENERAL_CALL_ADDR) && ownAddr[0];
	// only read requests are served here; write direction belongs to the receiver
	assign addrAck = ctrl.ackEnable && shiftReg[0] && (ownMatch || gcMatch); // R8

	// ----------------------------------------
	// protocol engine
	// ----------------------------------------
	logic midFrame;
	assign midFrame = (state == S_ADDR && bitCnt != 4'd0) || state == S_ADDR_ACK
		|| state == S_TX || state == S_TX_ACK;

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			state <= S_IDLE;
			jobComplete <= 1'b0;
			statusCode <= ST_NO_INFO;
			shiftReg <= 8'h00;
			bitCnt <= 4'd0;
			lastByte <= 1'b0;
			ackSeen <= 1'b0;
			gotAck <= 1'b0;
			startPending <= 1'b0;
			holdCnt <= 9'd0;
		end
		else
		begin
			if (resume)
				jobComplete <= 1'b0; // R17
			if (!ctrl.enable)
			begin
				state <= S_IDLE;
				startPending <= 1'b0;
			end
			else if (midFrame && (startDet || stopDet))
			begin
				state <= S_HOLD; // R11
				statusCode <= ST_BUS_ERROR; // R11
				jobComplete <= 1'b1; // R12
			end
			else
			begin
				case (state)
					S_IDLE:
					begin
						if (startDet)
						begin
							state <= S_ADDR;
							bitCnt <= 4'd0;
						end
						else if (startPending && !busBusy)
						begin
							state <= S_START; // R9
							holdCnt <= 9'd0;
						end
					end
					S_ADDR:
					begin
						if (startDet)
							bitCnt <= 4'd0; // R15
						else if (stopDet)
							state <= S_IDLE;
						else if (sclRise && bitCnt != 4'd8)
						begin
							shiftReg <= {shiftReg[6:0], sdaS2};
							bitCnt <= bitCnt + 4'd1;
						end
						else if (sclFall && bitCnt == 4'd8)
							state <= addrAck ? S_ADDR_ACK : S_IDLE; // R8
					end
					S_ADDR_ACK:
					begin
						if (sclFall)
						begin
							state <= S_HOLD;
							statusCode <= arbPending ? ST_ARB_READ : ST_OWN_READ; // R1 R4
							jobComplete <= 1'b1; // R1
						end
					end
					S_TX:
					begin
						if (sclFall)
						begin
							if (bitCnt == 4'd0)
							begin
								state <= S_TX_ACK;
								ackSeen <= 1'b0;
							end
							else
							begin
								shiftReg <= {shiftReg[6:0], 1'b1}; // R21
								bitCnt <= bitCnt - 4'd1;
							end
						end
					end
					S_TX_ACK:
					begin
						if (sclRise)
						begin
							gotAck <= !sdaS2;
							ackSeen <= 1'b1;
						end
						else if (sclFall && ackSeen)
						begin
							state <= S_HOLD;
							jobComplete <= 1'b1;
							if (!gotAck)
								statusCode <= ST_DATA_NACK; // R6
							else if (lastByte)
								statusCode <= ST_LAST_ACK; // R7
							else
								statusCode <= ST_DATA_ACK; // R5
						end
					end
					S_START:
					begin
						if (holdCnt == 9'(START_HOLD_CYC))
						begin
							state <= S_HOLD;
							statusCode <= ST_START_SENT;
							jobComplete <= 1'b1;
							startPending <= 1'b0;
						end
						else
							holdCnt <= holdCnt + 9'd1;
					end
					S_HOLD:
					begin
						if (resume)
						begin
							case (statusCode)
								ST_OWN_READ, ST_ARB_READ, ST_DATA_ACK:
								begin
									state <= S_TX;
									shiftReg <= dataReg; // R21
									bitCnt <= 4'd7;
									lastByte <= !hwdata[CB_ACK]; // R2 R3
								end
								ST_DATA_NACK, ST_LAST_ACK:
								begin
									state <= S_IDLE; // R6 R7
									startPending <= hwdata[CB_STA]; // R9
								end
								default:
									state <= S_IDLE; // R14
							endcase
						end
					end
					default:
						state <= S_IDLE;
				endcase
			end
		end
	end

	// ----------------------------------------
	// open-drain line drive
	// ----------------------------------------
	// a bus error leaves both lines released even while the flag waits
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			sclOe <= 1'b0;
			sdaOe <= 1'b0;
		end
		else
		begin
			sclOe <= (state == S_HOLD && jobComplete && statusCode != ST_BUS_ERROR) // R18 R14
				|| (state == S_START && holdCnt == 9'(START_HOLD_CYC));
			sdaOe <= state == S_ADDR_ACK || state == S_START
				|| (state == S_HOLD && statusCode == ST_START_SENT)
				|| (state == S_TX && !shiftReg[7]); // R21
		end
	end

	assign sclOut = 1'b0;
	assign sdaOut = 1'b0;

endmodule

/* i2c_slave_tx_assertions.sv */
// assertion checker for the slave-transmitter register port and line drivers
`timescale 1ns/10ps
module i2c_slave_tx_assertions
	import i2c_st_pkg::*;
#(
	parameter int ADDR_W = 32
)
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [ADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic sclOut,
	input wire logic sclOe,
	input wire logic sdaOut,
	input wire logic sdaOe,
	input wire logic jobComplete
);
	logic ctrlWr;
	logic clrNext;
	logic rdStat;
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// only a control write with the job bit set may clear the flag
	always_ff @(posedge ref_clk)
	begin
		ctrlWr <= rst_n && hsel && htrans[1] && hwrite && haddr == ADDR_W'(OFF_CTRL);
		clrNext <= rst_n && ctrlWr && hwdata[CB_JOB];
	end
	assign rdStat = hsel && htrans[1] && !hwrite && haddr == ADDR_W'(OFF_STATUS);
	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus answer not ready or not okay");
	a_lines_open_drain: assert property (!sclOut && !sdaOut)
		else $error("line driven high");
	a_rdata_upper_zero: assert property (hrdata[31:8] == 24'h0)
		else $error("read data upper bits not zero");
	a_rdata_stands: assert property (!(hsel && htrans[1] && !hwrite) |=> $stable(hrdata))
		else $error("read data changed without a read");
	a_no_info_status: assert property (rdStat && !jobComplete |=> hrdata[7:3] == 5'h1F)
		else $error("status not F8 while flag clear");
	a_status_bit2: assert property (rdStat |=> !hrdata[2])
		else $error("status bit 2 not zero");
	a_flag_sw_clear: assert property ($fell(jobComplete) |-> clrNext)
		else $error("flag cleared without software write");
	a_hold_while_flag: assert property (jobComplete && sclOe |=> sclOe || !jobComplete)
		else $error("clock released while flag set");
	a_scl_release: assert property ($fell(jobComplete) |-> ##[0:3] !sclOe)
		else $error("clock still held after resume");
endmodule
bind i2c_slave_tx i2c_slave_tx_assertions #(.ADDR_W(ADDR_W)) chk_u (.ref_clk(ref_clk),
	.rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
	.sclOut(sclOut), .sclOe(sclOe), .sdaOut(sdaOut), .sdaOe(sdaOe),
	.jobComplete(jobComplete));

/* i2c_st_pkg.sv */
// shared constants, types and register map of the two-wire slave-transmitter block
package i2c_st_pkg;

	// ----------------------------------------
	// register byte offsets
	// ----------------------------------------
	localparam logic [3:0] OFF_CTRL = 4'h0;
	localparam logic [3:0] OFF_STATUS = 4'h4;
	localparam logic [3:0] OFF_DATA = 4'h8;
	localparam logic [3:0] OFF_OWNADDR = 4'hC;

	// ----------------------------------------
	// bus_control_reg field positions
	// ----------------------------------------
	localparam int CB_JOB = 7;
	localparam int CB_ACK = 6;
	localparam int CB_STA = 5;
	localparam int CB_STO = 4;
	localparam int CB_WCOL = 3;
	localparam int CB_EN = 2;

	// ----------------------------------------
	// status codes (prescaler bits masked)
	// ----------------------------------------
	localparam logic [7:0] ST_OWN_READ = 8'hA8;
	localparam logic [7:0] ST_ARB_READ = 8'hB0;
	localparam logic [7:0] ST_DATA_ACK = 8'hB8;
	localparam logic [7:0] ST_DATA_NACK = 8'hC0;
	localparam logic [7:0] ST_LAST_ACK = 8'hC8;
	localparam logic [7:0] ST_NO_INFO = 8'hF8;
	localparam logic [7:0] ST_BUS_ERROR = 8'h00;
	localparam logic [7:0] ST_START_SENT = 8'h08;
	localparam logic [6:0] GENERAL_CALL_ADDR = 7'h00;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] RST_DATA = 8'hFF;
	localparam logic [7:0] RST_OWNADDR = 8'h00;
	localparam logic [1:0] RST_PRESCALE = 2'h0;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int START_HOLD_NS = 4000;
	localparam int START_HOLD_CYC = (START_HOLD_NS * CLK_MHZ + 999) / 1000;

	typedef enum logic [2:0] {S_IDLE, S_ADDR, S_ADDR_ACK, S_TX, S_TX_ACK, S_HOLD, S_START} state_e;

	typedef struct packed {
		logic ackEnable;
		logic startRequest;
		logic stopRequest;
		logic enable;
	} ctrl_s;

endpackage

/* tb.sv */
// bench: AHB-Lite register tasks and a bus-master model on the two-wire lines
`timescale 1ns/10ps
module tb;
	import i2c_st_pkg::*;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic arbLostInAddr = 1'b0;
	logic hreadyout, hresp, sclOut, sclOe, sdaOut, sdaOe, jobComplete, mScl, mSda, a;
	logic [31:0] hrdata;
	logic [7:0] b;
	int n_errors = 0;
	int compares = 0;
	wire logic sclW = !(sclOe || mScl);
	wire logic sdaW = !(sdaOe || mSda);
	always #5 ref_clk = ~ref_clk;
	i2c_slave_tx dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .arbLostInAddr(arbLostInAddr),
		.sclIn(sclW), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sdaW), .sdaOut(sdaOut),
		.sdaOe(sdaOe), .jobComplete(jobComplete));
	i2c_master_rx_model pm (.sclW(sclW), .sdaW(sdaW), .mScl(mScl), .mSda(mSda));
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic xfer(input logic w, input logic [3:0] ad, input logic [7:0] d,
		output logic [31:0] rd);
		@(posedge ref_clk);
		hsel <= 1'b1;
		haddr <= 32'(ad);
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= 32'(d);
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic wr(input logic [3:0] ad, input logic [7:0] d);
		logic [31:0] x;
		xfer(1'b1, ad, d, x);
	endtask
	task automatic rdChk(input logic [3:0] ad, input logic [7:0] e);
		logic [31:0] x;
		xfer(1'b0, ad, 8'h0, x);
		chk(x, 32'(e));
	endtask
	task automatic waitFlag();
		for (int i = 0; i < 2000 && jobComplete !== 1'b1; i++)
			@(posedge ref_clk);
		chk(32'(jobComplete), 32'h1);
	endtask
	// load, resume, let the master read one byte, then check the new status
	task automatic sendByte(input logic [7:0] d, input logic [7:0] ctl, input logic mAck,
		input logic [7:0] st);
		wr(OFF_DATA, d);
		wr(OFF_CTRL, ctl);
		pm.readByte(mAck, b);
		chk(32'(b), 32'(d));
		waitFlag();
		rdChk(OFF_STATUS, st);
	endtask
	task automatic tally_and_finish();
		$display("errors=%0d compares=%0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		#500000;
		n_errors++;
		tally_and_finish();
	end
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial
	begin
		repeat (8) @(posedge ref_clk);
		rst_n <= 1'b1;
		rdChk(OFF_OWNADDR, RST_OWNADDR);
		wr(OFF_DATA, 8'h11);
		rdChk(OFF_CTRL, 8'h08);
		rdChk(OFF_DATA, RST_DATA);
		rdChk(4'h2, 8'h0);
		wr(OFF_STATUS, 8'h03);
		rdChk(OFF_STATUS, 8'hFB);
		wr(OFF_STATUS, 8'h00);
		wr(OFF_OWNADDR, 8'h54);
		wr(OFF_CTRL, 8'h44);
		pm.start();
		pm.addrByte(7'h2A, a);
		chk(32'(a), 32'h0);
		waitFlag();
		rdChk(OFF_STATUS, ST_OWN_READ);
		chk(32'(sclOe), 32'h1);
		sendByte(8'hA5, 8'hC4, 1'b1, ST_DATA_ACK);
		sendByte(8'h3C, 8'h84, 1'b0, ST_DATA_NACK);
		wr(OFF_CTRL, 8'hA4);
		pm.stop();
		waitFlag();
		rdChk(OFF_STATUS, ST_START_SENT);
		chk(32'(sdaOe), 32'h1);
		wr(OFF_CTRL, 8'h84);
		pm.start();
		pm.addrByte(7'h2A, a);
		chk(32'(a), 32'h1);
		pm.stop();
		rdChk(OFF_STATUS, ST_NO_INFO);
		wr(OFF_CTRL, 8'h44);
		@(posedge ref_clk);
		arbLostInAddr <= 1'b1;
		@(posedge ref_clk);
		arbLostInAddr <= 1'b0;
		pm.start();
		pm.addrByte(7'h2A, a);
		chk(32'(a), 32'h0);
		waitFlag();
		rdChk(OFF_STATUS, ST_ARB_READ);
		sendByte(8'h81, 8'h84, 1'b1, ST_LAST_ACK);
		wr(OFF_CTRL, 8'hC4);
		// repeated start with no stop in between keeps the transfer atomic
		pm.start();
		pm.addrByte(7'h2A, a);
		chk(32'(a), 32'h0);
		waitFlag();
		sendByte(8'h5A, 8'h84, 1'b0, ST_DATA_NACK);
		wr(OFF_CTRL, 8'hC4);
		pm.stop();
		pm.start();
		pm.sendBits(8'hA0, 3);
		pm.start();
		waitFlag();
		rdChk(OFF_STATUS, ST_BUS_ERROR);
		chk({30'h0, sclOe, sdaOe}, 32'h0);
		wr(OFF_CTRL, 8'hD4);
		rdChk(OFF_CTRL, 8'h44);
		rdChk(OFF_STATUS, ST_NO_INFO);
		pm.stop();
		// general call is ignored until own-address bit 0 is set
		pm.start();
		pm.addrByte(7'h00, a);
		chk(32'(a), 32'h1);
		pm.stop();
		wr(OFF_OWNADDR, 8'h55);
		pm.start();
		pm.addrByte(7'h00, a);
		chk(32'(a), 32'h0);
		waitFlag();
		rdChk(OFF_STATUS, ST_OWN_READ);
		sendByte(8'hE7, 8'h84, 1'b0, ST_DATA_NACK);
		wr(OFF_CTRL, 8'h84);
		pm.stop();
		tally_and_finish();
	end
endmodule
